/* File: inc/dssc_defines.svh */
// Purpose: Constants for the drive system settings control block
// Assumes: 40 MHz system clock
// Notes: Frequencies in units of 0.1 kHz, voltages in volts
`ifndef DSSC_DEFINES_SVH
`define DSSC_DEFINES_SVH

`define DSSC_ADDR_CTRL 4'h0
`define DSSC_ADDR_THRESH 4'h1
`define DSSC_ADDR_FREQ 4'h2
`define DSSC_ADDR_STATUS 4'h3
`define DSSC_ADDR_OUT 4'h4

`define DSSC_CTRL_STOPKEY 0
`define DSSC_CTRL_STOPTYPE 1
`define DSSC_CTRL_HOLD 2
`define DSSC_CTRL_REDUCE 3
`define DSSC_CTRL_FAN_LO 4
`define DSSC_CTRL_FAN_HI 5
`define DSSC_CTRL_MODE_LO 6
`define DSSC_CTRL_MODE_HI 7

`define DSSC_CTRL_RST 8'h80
`define DSSC_MODE_SLV 2'h2

`define DSSC_THR_230_MIN 10'h14A
`define DSSC_THR_230_MAX 10'h18B
`define DSSC_THR_230_DEF 10'h17C
`define DSSC_THR_400_MIN 10'h294
`define DSSC_THR_400_MAX 10'h316
`define DSSC_THR_400_DEF 10'h2F8

`define DSSC_FREQ_MIN 8'h14
`define DSSC_FREQ_MIN_SLV 8'h15
`define DSSC_FREQ_MAX 8'h8C
`define DSSC_FREQ_DEF 8'h32

`define DSSC_FAN_RUNON_S 64'h12C
`define DSSC_CLK_HZ 64'h2625A00
`define DSSC_FAN_RUNON_CYC (`DSSC_FAN_RUNON_S * `DSSC_CLK_HZ)

`endif

/* File: inc/dssc_pkg.sv */
// Purpose: Types for the drive system settings control block
// Assumes: Used together with dssc_defines.svh
// Notes: None
package dssc_pkg;

    typedef enum logic [1:0] {
        DSSC_FAN_ALWAYS = 2'b00,
        DSSC_FAN_RUNON = 2'b01,
        DSSC_FAN_TEMP = 2'b10
    } dssc_fan_e;

    typedef enum logic [1:0] {
        DSSC_ST_IDLE = 2'b00,
        DSSC_ST_RAMP = 2'b01,
        DSSC_ST_HOLD = 2'b10,
        DSSC_ST_COAST = 2'b11
    } dssc_stop_e;

    typedef struct packed {
        logic keypad_stop;
        logic term_stop;
        logic term_reset;
        logic run;
        logic overtemp;
        logic hs_hot;
        logic dc_excess;
    } dssc_evt_s;

    typedef struct packed {
        logic ramp_down;
        logic ramp_hold;
        logic coast;
        logic fault_reset;
        logic init_trigger;
        logic ovolt_fault;
        logic fan_on;
    } dssc_act_s;

    typedef logic [7:0] dssc_freq_t;

endpackage

/* File: hdl/dssc_ctrl.sv */
// Purpose: Stop key, ramp hold, fan and pulse frequency control
// Assumes: All inputs synchronous to mclk; one clock domain
// Notes: Registers on a plain strobe port, read data one cycle later
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "dssc_defines.svh"

module dssc_ctrl #(
    parameter logic [63:0] FAN_RUNON_CYC = `DSSC_FAN_RUNON_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Straps and inputs
    input wire logic unit_400v,
    input wire logic keypad_fitted,
    input wire logic [9:0] dclink_volts,
    input wire dssc_pkg::dssc_evt_s evt,
    // Actions to power stage and fan
    output dssc_pkg::dssc_act_s act,
    output dssc_pkg::dssc_freq_t pulse_freq,
    output logic [7:0] fault_code
);
    import dssc_pkg::*;

    // Settings
    logic [7:0] ctrl_q;
    logic [9:0] thresh_q;
    dssc_freq_t freq_set_q;
    logic strap_done_q;

    // Stop path and faults
    dssc_stop_e stop_q;
    dssc_stop_e stop_d;
    logic ramp_down_q;
    logic ramp_hold_q;
    logic coast_q;
    logic fault_reset_q;
    logic init_trig_q;
    logic ovolt_q;
    logic [7:0] fault_q;

    // Fan and pulse frequency
    logic fan_on_q;
    logic [63:0] fan_cnt_q;
    logic run_q;
    dssc_freq_t freq_q;

    // Read port and assembled actions
    logic [15:0] rdata_q;
    dssc_act_s act_q;

    // Decoded settings and requests
    logic [9:0] thr_lo;
    logic [9:0] thr_hi;
    logic [9:0] thr_def;
    dssc_freq_t freq_lo;
    logic key_ok;
    logic stop_req;
    logic clr_req;
    logic over_thr;
    logic key_disable;
    logic coast_sel;
    logic slv_mode;
    dssc_fan_e fan_mode;

    assign key_disable = ctrl_q[`DSSC_CTRL_STOPKEY];
    assign coast_sel = ctrl_q[`DSSC_CTRL_STOPTYPE];
    assign fan_mode = dssc_fan_e'(ctrl_q[`DSSC_CTRL_FAN_HI:`DSSC_CTRL_FAN_LO]);
    assign slv_mode = ctrl_q[`DSSC_CTRL_MODE_HI:`DSSC_CTRL_MODE_LO] == `DSSC_MODE_SLV;
    assign thr_lo = unit_400v ? `DSSC_THR_400_MIN : `DSSC_THR_230_MIN;
    assign thr_hi = unit_400v ? `DSSC_THR_400_MAX : `DSSC_THR_230_MAX;
    assign thr_def = unit_400v ? `DSSC_THR_400_DEF : `DSSC_THR_230_DEF;
    assign freq_lo = slv_mode ? `DSSC_FREQ_MIN_SLV : `DSSC_FREQ_MIN;

    assign key_ok = keypad_fitted && evt.keypad_stop && !key_disable;
    assign stop_req = key_ok || evt.term_stop;
    // Fault indications cleared by key or terminal
    assign clr_req = key_ok || evt.term_reset;
    // Strictly above; equal counts as fallen back
    assign over_thr = dclink_volts > thresh_q;

    // Control register; mode bits default to SENSORLESS_VECTOR_MODE
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `DSSC_CTRL_RST;
        end else if (reg_wr && reg_addr == `DSSC_ADDR_CTRL) begin
            ctrl_q <= reg_wdata[7:0];
        end
    end

    // Threshold: default caught after reset, writes clamped to range
    // Strap default read once; write clamp limits follow the live pin
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            thresh_q <= 10'h000;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            thresh_q <= thr_def;
            strap_done_q <= 1'b1;
        end else if (reg_wr && reg_addr == `DSSC_ADDR_THRESH) begin
            if (reg_wdata[9:0] < thr_lo) begin
                thresh_q <= thr_lo;
            end else if (reg_wdata[9:0] > thr_hi) begin
                thresh_q <= thr_hi;
            end else begin
                thresh_q <= reg_wdata[9:0];
            end
        end
    end

    // Programmed pulse frequency
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            freq_set_q <= `DSSC_FREQ_DEF;
        end else if (reg_wr && reg_addr == `DSSC_ADDR_FREQ) begin
            if (reg_wdata[7:0] < `DSSC_FREQ_MIN) begin
                freq_set_q <= `DSSC_FREQ_MIN;
            end else if (reg_wdata[7:0] > `DSSC_FREQ_MAX) begin
                freq_set_q <= `DSSC_FREQ_MAX;
            end else begin
                freq_set_q <= reg_wdata[7:0];
            end
        end
    end

    // Effective pulse frequency
    // Reduction wins over the programmed value, never below floor
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            freq_q <= `DSSC_FREQ_DEF;
        end else if (ctrl_q[`DSSC_CTRL_REDUCE] && evt.overtemp) begin
            freq_q <= freq_lo;
        end else if (freq_set_q < freq_lo) begin
            freq_q <= freq_lo;
        end else begin
            freq_q <= freq_set_q;
        end
    end

    // Stop sequencing
    // Only a run command without a new stop returns ramp or coast to idle
    always_comb begin
        stop_d = stop_q;
        case (stop_q)
            DSSC_ST_IDLE: begin
                if (stop_req) begin
                    stop_d = coast_sel ? DSSC_ST_COAST : DSSC_ST_RAMP;
                end
            end
            DSSC_ST_RAMP: begin
                if (evt.run && !stop_req) begin
                    stop_d = DSSC_ST_IDLE;
                end else if (ctrl_q[`DSSC_CTRL_HOLD] && over_thr) begin
                    stop_d = DSSC_ST_HOLD;
                end
            end
            DSSC_ST_HOLD: begin
                if (!ctrl_q[`DSSC_CTRL_HOLD] || !over_thr) begin
                    stop_d = DSSC_ST_RAMP;
                end
            end
            DSSC_ST_COAST: begin
                if (evt.run && !stop_req) begin
                    stop_d = DSSC_ST_IDLE;
                end
            end
            default: begin
                stop_d = DSSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_q <= DSSC_ST_IDLE;
        end else begin
            stop_q <= stop_d;
        end
    end

    // Stop state outputs, one cycle after cause
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_down_q <= 1'b0;
            ramp_hold_q <= 1'b0;
            coast_q <= 1'b0;
        end else begin
            ramp_down_q <= stop_d == DSSC_ST_RAMP;
            ramp_hold_q <= stop_d == DSSC_ST_HOLD;
            coast_q <= stop_d == DSSC_ST_COAST;
        end
    end

    // Pulses last one cycle per cycle of cause
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_reset_q <= 1'b0;
            init_trig_q <= 1'b0;
        end else begin
            fault_reset_q <= clr_req;
            init_trig_q <= key_ok;
        end
    end

    // Sticky; a new excess wins over reset
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ovolt_q <= 1'b0;
        end else if (evt.dc_excess) begin
            ovolt_q <= 1'b1;
        end else if (clr_req) begin
            ovolt_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= 8'h00;
        end else if (evt.dc_excess) begin
            fault_q <= 8'h07;
        end else if (clr_req) begin
            fault_q <= 8'h00;
        end
    end

    // Fan run-on timer; starts loaded for the power-up check
    // Wide enough for the full run-on at the system clock
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            run_q <= 1'b0;
            fan_cnt_q <= 64'h0;
        end else begin
            run_q <= evt.run;
            if (!strap_done_q) begin
                fan_cnt_q <= FAN_RUNON_CYC;
            end else if (evt.run != run_q || stop_req) begin
                fan_cnt_q <= FAN_RUNON_CYC;
            end else if (fan_cnt_q != 64'h0) begin
                fan_cnt_q <= fan_cnt_q - 64'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fan_on_q <= 1'b1;
        end else begin
            case (fan_mode)
                DSSC_FAN_ALWAYS: begin
                    fan_on_q <= 1'b1;
                end
                DSSC_FAN_RUNON: begin
                    fan_on_q <= evt.run || fan_cnt_q != 64'h0;
                end
                DSSC_FAN_TEMP: begin
                    fan_on_q <= evt.hs_hot;
                end
                default: begin
                    fan_on_q <= 1'b1;
                end
            endcase
        end
    end

    // Register read, data one cycle after strobe
    // Zero outside the answer cycle, so reads can be OR-ed
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `DSSC_ADDR_CTRL) begin
                rdata_q <= {8'h00, ctrl_q};
            end else if (reg_addr == `DSSC_ADDR_THRESH) begin
                rdata_q <= {6'h00, thresh_q};
            end else if (reg_addr == `DSSC_ADDR_FREQ) begin
                rdata_q <= {8'h00, freq_set_q};
            end else if (reg_addr == `DSSC_ADDR_STATUS) begin
                rdata_q <= {6'h00, stop_q, fault_q};
            end else if (reg_addr == `DSSC_ADDR_OUT) begin
                rdata_q <= {1'b0, act_q, freq_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // Outputs straight from flops
    assign act_q = {ramp_down_q, ramp_hold_q, coast_q, fault_reset_q, init_trig_q, ovolt_q,
        fan_on_q};
    assign reg_rdata = rdata_q;
    assign act = act_q;
    assign pulse_freq = freq_q;
    assign fault_code = fault_q;

endmodule

/* File: verification/dssc_ctrl_chk.sv */
// Purpose: Port checker for dssc_ctrl
// Assumes: CTRL shadowed from write strobes, reset 80
// Notes: Bound into every dssc_ctrl instance
`timescale 1ns/10ps
module dssc_ctrl_chk
    import dssc_pkg::*;
#(
    parameter logic [63:0] FAN_RUNON_CYC = 64'h32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Straps and inputs
    input wire logic unit_400v,
    input wire logic keypad_fitted,
    input wire logic [9:0] dclink_volts,
    input wire dssc_pkg::dssc_evt_s evt,
    // Design outputs
    input wire dssc_pkg::dssc_act_s act,
    input wire dssc_pkg::dssc_freq_t pulse_freq,
    input wire logic [7:0] fault_code
);
    logic [7:0] ctrl_q;
    logic key_ok;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= 8'h80;
        end else if (reg_wr && reg_addr == 4'h0) begin
            ctrl_q <= reg_wdata[7:0];
        end
    end
    assign key_ok = evt.keypad_stop && keypad_fitted && !ctrl_q[0];
    property p_key_act; key_ok |=> act.fault_reset && act.init_trigger; endproperty
    a_key_act: assert property (p_key_act) else $error("stop key actions missing");
    property p_key_off;
        evt.keypad_stop && !key_ok && !evt.term_stop && !evt.term_reset |=> !act.init_trigger;
    endproperty
    a_key_off: assert property (p_key_off) else $error("refused stop key acted");
    property p_coast; key_ok && ctrl_q[1] |=> act.coast && !act.ramp_down; endproperty
    a_coast: assert property (p_coast) else $error("coast stop missing");
    property p_ramp; key_ok && !ctrl_q[1] |=> !act.coast && (act.ramp_down || act.ramp_hold); endproperty
    a_ramp: assert property (p_ramp) else $error("ramp stop missing");
    property p_hold_off; !ctrl_q[2] |=> !act.ramp_hold; endproperty
    a_hold_off: assert property (p_hold_off) else $error("hold while disabled");
    property p_ovolt; evt.dc_excess |=> act.ovolt_fault && fault_code == 8'h07; endproperty
    a_ovolt: assert property (p_ovolt) else $error("overvoltage fault missing");
    property p_fan0; ctrl_q[5:4] == 2'h0 |=> act.fan_on; endproperty
    a_fan0: assert property (p_fan0) else $error("fan off in mode 0");
    property p_fan2; ctrl_q[5:4] == 2'h2 |=> act.fan_on == $past(evt.hs_hot); endproperty
    a_fan2: assert property (p_fan2) else $error("fan not following heat sink");
    property p_range; pulse_freq >= 8'h14 && pulse_freq <= 8'h8C; endproperty
    a_range: assert property (p_range) else $error("pulse frequency out of range");
    property p_slv; ctrl_q[7:6] == 2'h2 |=> pulse_freq >= 8'h15; endproperty
    a_slv: assert property (p_slv) else $error("pulse frequency below vector floor");
    property p_red;
        ctrl_q[3] && evt.overtemp |=> pulse_freq == ($past(ctrl_q[7:6]) == 2'h2 ? 8'h15 : 8'h14);
    endproperty
    a_red: assert property (p_red) else $error("overtemp reduction wrong");
endmodule
bind dssc_ctrl dssc_ctrl_chk #(.FAN_RUNON_CYC(FAN_RUNON_CYC)) u_chk (.mclk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .unit_400v, .keypad_fitted,
    .dclink_volts, .evt, .act, .pulse_freq, .fault_code);

/* File: verification/dssc_plant.sv */
// Purpose: Power stage model for the DC link voltage
// Assumes: Regeneration only while ramping with regen_on
// Notes: One volt a cycle keeps runs short
`timescale 1ns/10ps
module dssc_plant
    import dssc_pkg::*;
#(
    parameter logic [9:0] BASE_V = 10'h168,
    parameter logic [9:0] TRIP_V = 10'h190
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Drive state
    input wire dssc_pkg::dssc_act_s act,
    input wire logic regen_on,
    // Measurements
    output logic [9:0] dclink_volts,
    output logic dc_excess
);
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dclink_volts <= BASE_V;
        end else if (act.ramp_down && regen_on) begin
            dclink_volts <= dclink_volts + 10'h1;
        end else if (dclink_volts > BASE_V) begin
            // Held or coasting motor lets the link bleed
            dclink_volts <= dclink_volts - 10'h1;
        end
    end
    assign dc_excess = dclink_volts > TRIP_V;
endmodule

/* File: verification/tb_dssc_ctrl.sv */
// Purpose: Self-checking bench for dssc_ctrl
// Assumes: Fan run-on shortened to 50 cycles
// Notes: Plant model supplies the DC link voltage
`timescale 1ns/10ps
module tb_dssc_ctrl;
    import dssc_pkg::*;
    logic mclk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, unit_400v = 1'h0;
    logic keypad_fitted = 1'h1, regen_on = 1'h0, exc;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic [9:0] dclink_volts;
    logic [7:0] fault_code;
    dssc_evt_s evt, evt_b = '0;
    dssc_act_s act;
    dssc_freq_t pulse_freq;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    always_comb begin
        evt = evt_b;
        evt.dc_excess = exc;
    end
    dssc_ctrl #(.FAN_RUNON_CYC(64'h32)) uut (.mclk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .unit_400v, .keypad_fitted, .dclink_volts, .evt,
        .act, .pulse_freq, .fault_code);
    dssc_plant plant (.mclk, .sys_rst, .act, .regen_on, .dclink_volts, .dc_excess(exc));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // Hang guard, far above the few hundred cycles used
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Checks %0d, errors %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset(input logic u);
        unit_400v <= u;
        sys_rst <= 1'h1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'h0;
        wait_cy(2);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk("rdata", reg_rdata, e);
    endtask
    task automatic pulse(input int b);
        @(posedge mclk);
        evt_b[b] <= 1'h1;
        @(posedge mclk);
        evt_b[b] <= 1'h0;
        #1;
    endtask
    task automatic wait_act(input int b);
        int n;
        n = 0;
        while (act[b] !== 1'h1 && n < 200) begin
            wait_cy(1);
            n++;
        end
    endtask
    task automatic fcase(input logic [7:0] c, input logic [7:0] w, input logic ot,
            input logic [7:0] er, input logic [7:0] ep);
        evt_b.overtemp <= ot;
        wr(4'h0, {8'h0, c});
        wr(4'h2, {8'h0, w});
        rd(4'h2, {8'h0, er});
        chk("freq", pulse_freq, ep);
    endtask
    initial begin
        do_reset(1'h0);
        chk("act", act, 16'h01);
        chk("freq", pulse_freq, 16'h32);
        rd(4'h0, 16'h0080);
        rd(4'h1, 16'h017C);
        rd(4'h4, 16'h0132);
        rd(4'h7, 16'h0000);
        wr(4'h0, 16'h0090);
        wait_cy(20);
        chk("fan", act.fan_on, 16'h1);
        wait_cy(40);
        chk("fan", act.fan_on, 16'h0);
        evt_b.run <= 1'h1;
        wait_cy(80);
        chk("fan", act.fan_on, 16'h1);
        evt_b.run <= 1'h0;
        pulse(5);
        wait_cy(30);
        pulse(5);
        wait_cy(40);
        chk("fan", act.fan_on, 16'h1);
        wait_cy(20);
        chk("fan", act.fan_on, 16'h0);
        wr(4'h0, 16'h00A0);
        for (int h = 0; h < 2; h++) begin
            evt_b.hs_hot <= h[0];
            wait_cy(3);
            chk("fan", act.fan_on, h[0]);
        end
        // Every control mode, both stop types
        for (int m = 0; m < 8; m++) begin
            wr(4'h0, {8'h0, m[1:0], 4'h0, m[2], 1'h0});
            pulse(3);
            pulse(6);
            chk("act", act[6:2], m[2] ? 16'h07 : 16'h13);
        end
        for (int k = 0; k < 2; k++) begin
            keypad_fitted <= k[0];
            wr(4'h0, {15'h0, k[0]});
            pulse(3);
            pulse(6);
            chk("act", act[6:2], 16'h00);
        end
        pulse(5);
        chk("ramp", act.ramp_down, 16'h1);
        keypad_fitted <= 1'h1;
        wr(4'h0, 16'h0084);
        regen_on <= 1'h1;
        pulse(3);
        pulse(6);
        wait_act(5);
        chk("hold", act.ramp_hold, 16'h1);
        chk("above", dclink_volts > 10'h17C, 16'h1);
        wait_act(6);
        chk("resume", act.ramp_down, 16'h1);
        chk("below", dclink_volts <= 10'h17C, 16'h1);
        wait_cy(100);
        chk("code", fault_code, 16'h00);
        wr(4'h0, 16'h0080);
        pulse(3);
        pulse(6);
        wait_act(1);
        chk("ovolt", act.ovolt_fault, 16'h1);
        chk("code", fault_code, 16'h07);
        rd(4'h3, 16'h0107);
        regen_on <= 1'h0;
        wait_cy(60);
        pulse(4);
        chk("code", fault_code, 16'h00);
        chk("ovolt", act.ovolt_fault, 16'h0);
        fcase(8'h80, 8'h05, 1'h0, 8'h14, 8'h15);
        fcase(8'h00, 8'h05, 1'h0, 8'h14, 8'h14);
        fcase(8'h00, 8'hFF, 1'h0, 8'h8C, 8'h8C);
        fcase(8'h08, 8'h64, 1'h1, 8'h64, 8'h14);
        fcase(8'h88, 8'h64, 1'h1, 8'h64, 8'h15);
        fcase(8'h80, 8'h64, 1'h1, 8'h64, 8'h64);
        wr(4'h1, 16'h0100);
        rd(4'h1, 16'h014A);
        wr(4'h1, 16'h03FF);
        rd(4'h1, 16'h018B);
        do_reset(1'h1);
        rd(4'h1, 16'h02F8);
        wr(4'h1, 16'h0200);
        rd(4'h1, 16'h0294);
        test_done();
    end
endmodule
